/* rtl/lpm_ctrl.sv */
// Low-power mode controller: wait, active halt and halt sequencing.
`timescale 1ns/100ps
module lpm_ctrl
  import lpm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wait_for_irq_instruction,
  input wire logic i_halt_req,
  input wire logic i_oscillator_irq_enable,
  input wire logic i_watchdog_halt_option,
  input wire logic i_watchdog_active,
  input wire logic i_slow_mode,
  input wire logic i_irq_ack,
  input wire logic i_irq_return,
  input wire lpm_wake_t i_wake,
  output logic o_cpu_stall,
  output logic o_wake_done,
  output logic o_wake_by_irq,
  output logic o_irq_mask,
  output logic o_push_ccr,
  output logic o_slow_wait,
  output logic o_watchdog_reset,
  output lpm_clk_t o_clk,
  output lpm_state_t o_state
);
  // Interrupt lines come from other clock domains and pins.
  lpm_wake_t wake_s;
  lpm_sync u_sync_tb (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_d(i_wake.timebase_irq), .o_q(wake_s.timebase_irq));
  lpm_sync u_sync_cs (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_d(i_wake.security_irq), .o_q(wake_s.security_irq));
  lpm_sync u_sync_ex (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_d(i_wake.ext_irq), .o_q(wake_s.ext_irq));
  lpm_sync u_sync_ot (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_d(i_wake.other_irq), .o_q(wake_s.other_irq));

  lpm_state_t state_q, state_d;
  logic [12:0] cnt_q, cnt_d;
  logic mask_q, mask_d;
  logic stall_q, stall_d;
  logic done_q, done_d;
  logic by_irq_q, by_irq_d;
  logic push_q, push_d;
  logic slow_wait_q, slow_wait_d;
  logic wdg_rst_q, wdg_rst_d;
  lpm_clk_t clk_q, clk_d;

  wire any_irq = |wake_s;
  wire halt_exit = wake_s.ext_irq;
  wire ahalt_exit = halt_exit | wake_s.timebase_irq
    | wake_s.security_irq;
  wire halt_wdg_bad = i_watchdog_active & ~i_watchdog_halt_option;
  wire cnt_end = (cnt_q == STARTUP_LAST);

  always_comb begin
    state_d = state_q;
    cnt_d = CNT_ZERO;
    mask_d = mask_q;
    stall_d = stall_q;
    done_d = 1'b0;
    by_irq_d = by_irq_q;
    push_d = 1'b0;
    slow_wait_d = 1'b0;
    wdg_rst_d = 1'b0;
    clk_d = '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1,
              timebase_clk_en: 1'b1};
    case (state_q)
      LPM_RUN: begin
        if (i_irq_ack) begin
          mask_d = 1'b1;
          push_d = 1'b1;
        end else if (i_irq_return) begin
          mask_d = 1'b0;
        end
        if (i_wait_for_irq_instruction) begin
          state_d = LPM_WAIT;
          mask_d = 1'b0;
          stall_d = 1'b1;
          clk_d.cpu_clk_en = 1'b0;
          slow_wait_d = i_slow_mode;
        end else if (i_halt_req) begin
          stall_d = 1'b1;
          mask_d = 1'b0;
          clk_d.cpu_clk_en = 1'b0;
          clk_d.periph_clk_en = 1'b0;
          if (i_oscillator_irq_enable) begin
            state_d = LPM_AHALT;
          end else begin
            state_d = LPM_HALT;
            clk_d.osc_en = 1'b0;
            clk_d.timebase_clk_en = 1'b0;
            wdg_rst_d = halt_wdg_bad;
          end
        end
      end
      LPM_WAIT: begin
        clk_d.cpu_clk_en = 1'b0;
        slow_wait_d = i_slow_mode;
        if (any_irq) begin
          state_d = LPM_RESUME;
          by_irq_d = 1'b1;
        end
      end
      LPM_AHALT: begin
        clk_d.cpu_clk_en = 1'b0;
        clk_d.periph_clk_en = 1'b0;
        // No watchdog reset here, whether or not the oscillator enable stays set.
        wdg_rst_d = 1'b0;
        if (ahalt_exit) begin
          state_d = LPM_START;
          by_irq_d = 1'b1;
        end
      end
      LPM_HALT: begin
        clk_d = '{cpu_clk_en: 1'b0, periph_clk_en: 1'b0, osc_en: 1'b0,
                  timebase_clk_en: 1'b0};
        if (halt_exit) begin
          // The oscillator restarts at once so that it can settle.
          state_d = LPM_START;
          by_irq_d = 1'b1;
          clk_d.osc_en = 1'b1;
        end
      end
      LPM_START: begin
        // Oscillator runs again while the CPU waits for it to settle.
        clk_d.cpu_clk_en = 1'b0;
        clk_d.periph_clk_en = 1'b0;
        cnt_d = 13'(cnt_q + 13'h0001);
        if (cnt_end) begin
          state_d = LPM_RESUME;
          cnt_d = CNT_ZERO;
        end
      end
      default: begin
        state_d = LPM_RUN;
        stall_d = 1'b0;
        done_d = 1'b1;
        mask_d = 1'b1;
        push_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_q <= LPM_RUN;
      cnt_q <= CNT_ZERO;
      mask_q <= 1'b1;
      stall_q <= 1'b0;
      done_q <= 1'b0;
      by_irq_q <= 1'b0;
      push_q <= 1'b0;
      slow_wait_q <= 1'b0;
      wdg_rst_q <= 1'b0;
      clk_q <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1,
                 timebase_clk_en: 1'b1};
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      mask_q <= mask_d;
      stall_q <= stall_d;
      done_q <= done_d;
      by_irq_q <= (state_q == LPM_RUN) ? 1'b0 : by_irq_d;
      push_q <= push_d;
      slow_wait_q <= slow_wait_d;
      wdg_rst_q <= wdg_rst_d;
      clk_q <= clk_d;
    end
  end

  assign o_state = state_q;
  assign o_cpu_stall = stall_q;
  assign o_wake_done = done_q;
  assign o_wake_by_irq = by_irq_q;
  assign o_irq_mask = mask_q;
  assign o_push_ccr = push_q;
  assign o_slow_wait = slow_wait_q;
  assign o_watchdog_reset = wdg_rst_q;
  assign o_clk = clk_q;

  property p_wait_entry;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_RUN && i_wait_for_irq_instruction) |=>
      (state_q == LPM_WAIT && !mask_q && stall_q && clk_q.periph_clk_en);
  endproperty
  a_wait_entry: assert property (p_wait_entry)
    else $error("wait entry wrong");

  property p_halt_select;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_RUN && !i_wait_for_irq_instruction && i_halt_req) |=>
      (state_q == ($past(i_oscillator_irq_enable) ? LPM_AHALT : LPM_HALT)
       && !mask_q);
  endproperty
  a_halt_select: assert property (p_halt_select)
    else $error("halt mode selection wrong");

  property p_wait_wake;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_WAIT && any_irq) |=> state_q == LPM_RESUME
      ##1 (state_q == LPM_RUN && done_q && !stall_q && mask_q);
  endproperty
  a_wait_wake: assert property (p_wait_wake)
    else $error("wait wake-up wrong");

  property p_halt_no_tb;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_HALT && !wake_s.ext_irq) |=> state_q == LPM_HALT;
  endproperty
  a_halt_no_tb: assert property (p_halt_no_tb)
    else $error("halt left without external irq");

  property p_ahalt_exit;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_AHALT && wake_s.timebase_irq) |=> state_q == LPM_START;
  endproperty
  a_ahalt_exit: assert property (p_ahalt_exit)
    else $error("active halt not left on timebase");

  // Counts the cycles spent in start-up for the length checks below.
  logic [12:0] start_cyc_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      start_cyc_q <= CNT_ZERO;
    end else if (state_q == LPM_START) begin
      start_cyc_q <= 13'(start_cyc_q + 13'h0001);
    end else begin
      start_cyc_q <= CNT_ZERO;
    end
  end

  property p_startup_len;
    @(posedge i_clk) disable iff (!i_rst_b)
    $fell(state_q == LPM_START) |->
      (state_q == LPM_RESUME && start_cyc_q == 13'(STARTUP_CYCLES));
  endproperty
  a_startup_len: assert property (p_startup_len)
    else $error("start-up delay wrong");

  property p_halt_clocks;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_HALT && $past(state_q) == LPM_HALT) |->
      (!clk_q.osc_en && !clk_q.periph_clk_en && !clk_q.cpu_clk_en);
  endproperty
  a_halt_clocks: assert property (p_halt_clocks)
    else $error("clocks running in halt");

  property p_ahalt_clocks;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_AHALT) |->
      (clk_q.osc_en && clk_q.timebase_clk_en && !clk_q.periph_clk_en);
  endproperty
  a_ahalt_clocks: assert property (p_ahalt_clocks)
    else $error("active halt clocks wrong");

  property p_no_wdg_ahalt;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_AHALT) |=> !wdg_rst_q;
  endproperty
  a_no_wdg_ahalt: assert property (p_no_wdg_ahalt)
    else $error("watchdog reset in active halt");

  property p_wdg_halt;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_RUN && !i_wait_for_irq_instruction && i_halt_req
     && !i_oscillator_irq_enable) |=> wdg_rst_q == $past(halt_wdg_bad);
  endproperty
  a_wdg_halt: assert property (p_wdg_halt)
    else $error("watchdog halt option ignored");

  property p_startup_bound;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_START) |-> (start_cyc_q < 13'(STARTUP_CYCLES));
  endproperty
  a_startup_bound: assert property (p_startup_bound)
    else $error("start-up delay overrun");

  property p_wait_clocks;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_WAIT) |->
      (!clk_q.cpu_clk_en && clk_q.periph_clk_en && clk_q.osc_en);
  endproperty
  a_wait_clocks: assert property (p_wait_clocks)
    else $error("wait clocks wrong");

  property p_slow_wait;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_WAIT) |-> (slow_wait_q == $past(i_slow_mode));
  endproperty
  a_slow_wait: assert property (p_slow_wait)
    else $error("slow wait flag wrong");

  property p_stall_low_power;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q != LPM_RUN) |-> stall_q;
  endproperty
  a_stall_low_power: assert property (p_stall_low_power)
    else $error("cpu not stalled in low power");

  property p_done_pulse;
    @(posedge i_clk) disable iff (!i_rst_b)
    done_q |-> (state_q == LPM_RUN && $past(state_q) == LPM_RESUME);
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("wake done pulse misplaced");

  property p_halt_exit_osc;
    @(posedge i_clk) disable iff (!i_rst_b)
    (state_q == LPM_HALT && wake_s.ext_irq) |=>
      (state_q == LPM_START && clk_q.osc_en);
  endproperty
  a_halt_exit_osc: assert property (p_halt_exit_osc)
    else $error("oscillator not restarted on halt exit");
endmodule

/* rtl/lpm_pkg.sv */
// Package with constants and types of the low-power mode controller.
package lpm_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned STARTUP_CYCLES = 4096;
  localparam logic [12:0] STARTUP_LAST = 13'(STARTUP_CYCLES - 1);
  localparam logic [12:0] CNT_ZERO = 13'h0000;

  typedef enum logic [2:0] {
    LPM_RUN = 3'b000,
    LPM_WAIT = 3'b001,
    LPM_AHALT = 3'b010,
    LPM_HALT = 3'b011,
    LPM_START = 3'b100,
    LPM_RESUME = 3'b101
  } lpm_state_t;

  typedef struct packed {
    logic timebase_irq;
    logic security_irq;
    logic ext_irq;
    logic other_irq;
  } lpm_wake_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic timebase_clk_en;
  } lpm_clk_t;
endpackage

/* rtl/lpm_sync.sv */
// Two-flop synchroniser for an asynchronous level.
`timescale 1ns/100ps
module lpm_sync (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_d,
  output logic o_q
);
  logic meta_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_q <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule

/* testbench/lpm_cpu_model.sv */
// CPU core model issuing wait, halt and handler pulses to the controller.
`timescale 1ns/100ps
module lpm_cpu_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_go,
  input wire logic i_cpu_stall,
  input wire logic i_wake_done,
  output logic o_wfi,
  output logic o_halt,
  output logic o_ack,
  output logic o_ret
);
  logic busy_q;
  // A core that has issued wait or halt stays stalled until wake-up ends.
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      {busy_q, o_wfi, o_halt, o_ack, o_ret} <= 5'h00;
    end else begin
      o_wfi <= i_go[3] & ~busy_q;
      o_halt <= i_go[2] & ~busy_q;
      o_ack <= i_go[1] & ~busy_q & ~i_cpu_stall;
      o_ret <= i_go[0] & ~busy_q & ~i_cpu_stall;
      if (i_go[3] | i_go[2]) busy_q <= 1'b1;
      else if (i_wake_done) busy_q <= 1'b0;
    end
  end
endmodule

/* testbench/tb_lpm_ctrl.sv */
// Self-checking bench for the low-power mode controller.
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  miscompares++; $display("ERROR %0t got %0h exp %0h", $time, a, b); \
  end end
module tb_lpm_ctrl;
  import lpm_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] go = 4'h0;
  logic [3:0] cfg = 4'h0;
  lpm_wake_t wake = '0;
  logic wait_for_irq_instruction, hlt, ack, ret, stall, done, by_irq, mask, push, swait, wdrst;
  lpm_clk_t clk_en;
  lpm_state_t state;
  int miscompares = 0;
  int n_checks = 0;
  int starts;
  int wd_pulses = 0;
  int wd_base = 0;

  initial forever #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (wdrst === 1'b1) wd_pulses <= wd_pulses + 1;

  lpm_cpu_model cpu (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_go(go),
    .i_cpu_stall(stall), .i_wake_done(done), .o_wfi(wait_for_irq_instruction), .o_halt(hlt),
    .o_ack(ack), .o_ret(ret));
  lpm_ctrl uut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_wait_for_irq_instruction(wait_for_irq_instruction), .i_halt_req(hlt),
    .i_oscillator_irq_enable(cfg[3]), .i_watchdog_halt_option(cfg[2]),
    .i_watchdog_active(cfg[1]), .i_slow_mode(cfg[0]), .i_irq_ack(ack),
    .i_irq_return(ret), .i_wake(wake), .o_cpu_stall(stall),
    .o_wake_done(done), .o_wake_by_irq(by_irq), .o_irq_mask(mask),
    .o_push_ccr(push), .o_slow_wait(swait), .o_watchdog_reset(wdrst),
    .o_clk(clk_en), .o_state(state));

  task automatic finish_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic issue(logic [3:0] g);
    @(posedge i_clk) go <= g;
    @(posedge i_clk) go <= 4'h0;
    #1;
  endtask

  task automatic set_in(logic [3:0] c, lpm_wake_t w);
    @(posedge i_clk) cfg <= c;
    wake <= w;
    #1;
  endtask

  task automatic wait_state(lpm_state_t s);
    for (int i = 0; i < 20 && state !== s; i++) tick(1);
    `CHK(state, s)
    if (state !== s) finish_test();
  endtask

  // Waits for the done pulse, counting start-up cycles on the way.
  task automatic wait_done();
    starts = 0;
    for (int i = 0; i < 5000 && done !== 1'b1; i++) begin
      if (state === LPM_START) starts++;
      tick(1);
    end
    `CHK(done, 1'b1)
    if (done !== 1'b1) finish_test();
    `CHK({stall, mask, push, by_irq}, 4'h7)
    set_in(cfg, '0);
  endtask

  task automatic enter(logic [3:0] g, logic [3:0] c, lpm_state_t s,
                       logic [3:0] ce);
    set_in(c, '0);
    wd_base = wd_pulses;
    issue(g);
    wait_state(s);
    `CHK(clk_en, ce)
    `CHK(mask, 1'b0)
  endtask

  initial begin
    tick(10);
    @(posedge i_clk) i_rst_b <= 1'b1;
    #1;
    `CHK({state, mask, clk_en, stall}, {LPM_RUN, 1'b1, 4'hf, 1'b0})
    issue(4'h1);
    tick(2);
    `CHK(mask, 1'b0)
    issue(4'h2);
    tick(1);
    `CHK({mask, push}, 2'h3)
    enter(4'h8, 4'h0, LPM_WAIT, 4'h7);
    `CHK({swait, stall}, 2'h1)
    set_in(cfg, 4'h1);
    wait_done();
    enter(4'h8, 4'h1, LPM_WAIT, 4'h7);
    `CHK(swait, 1'b1)
    set_in(cfg, 4'h2);
    wait_done();
    enter(4'h4, 4'ha, LPM_AHALT, 4'h3);
    set_in(cfg, 4'h1);
    tick(10);
    `CHK({state, wd_pulses != wd_base}, {LPM_AHALT, 1'b0})
    set_in(cfg, 4'h8);
    wait_done();
    `CHK(starts, STARTUP_CYCLES)
    enter(4'h4, 4'h2, LPM_HALT, 4'h0);
    `CHK(wdrst, 1'b1)
    set_in(cfg, 4'hd);
    tick(10);
    `CHK(state, LPM_HALT)
    set_in(cfg, 4'h2);
    wait_done();
    `CHK(starts, STARTUP_CYCLES)
    set_in(4'h6, 4'h2);
    wd_base = wd_pulses;
    issue(4'h4);
    wait_done();
    `CHK({starts, wd_pulses != wd_base}, {STARTUP_CYCLES, 1'b0})
    enter(4'h8, 4'h0, LPM_WAIT, 4'h7);
    @(posedge i_clk) i_rst_b <= 1'b0;
    tick(2);
    `CHK({state, mask, stall}, {LPM_RUN, 2'h2})
    finish_test();
  end
endmodule
